/* logic/serial_rx_err_regs.vh */
`ifndef SERIAL_RX_ERR_REGS_VH
`define SERIAL_RX_ERR_REGS_VH
// register indices; byte address is four times the index
`define CFG_INDEX        20'hFF48
`define CTRL_INDEX       20'hFF49
`define IRQ_CTRL_INDEX   20'hFF4C
`define IRQ_FLAG_INDEX   20'hFF4D
`define CFG_ADDR         20'h3FD20
`define CTRL_ADDR        20'h3FD24
`define IRQ_CTRL_ADDR    20'h3FD30
`define IRQ_FLAG_ADDR    20'h3FD34
// serial_config fields
`define CFG_PIN_SEL      0
`define CFG_MODE_LO      1
`define CFG_MODE_HI      2
`define CFG_SRC_LO       3
`define CFG_SRC_HI       4
`define CFG_ODD          5
`define CFG_PAR_EN       6
`define CFG_RESET        7'h00
// serial_control_status fields
`define CTRL_TX_PERMIT   0
`define CTRL_RX_PERMIT   2
`define CTRL_RELEASE     3
`define CTRL_OVERRUN     4
`define CTRL_PARITY      5
`define CTRL_FRAME       6
// irq control and flag fields
`define IRQ_TX           0
`define IRQ_RX           1
`define IRQ_ERR          2
`define IRQ_PRIO_LO      4
`define IRQ_PRIO_HI      5
// vector addresses
`define VEC_TX_DONE      24'h00002C
`define VEC_RX_DONE      24'h00002A
`define VEC_ERROR        24'h000028
// oversampling: last tick of each 16-tick bit and mid-bit point
`define OS_LAST          4'hF
`define OS_MID           4'h7
// axi responses
`define RESP_OKAY        2'h0
`define RESP_SLVERR      2'h2
`endif

/* logic/async_serial_rx_errors_and_irq.v */
`timescale 1ns/1ns
`include "serial_rx_err_regs.vh"
// Notes on behaviour
// - with parity on, check each character at buffer load; mismatch sets parity and error flags
// - even parity: ones over data plus parity even; odd parity: odd
// - no parity check or parity error while parity is disabled
// - parity error flag clears on writing 1; writing 0 does nothing
// - stop bit sampled low sets framing error and error flags
// - framing error flag clears on writing 1; writing 0 does nothing
// - erroneous characters are still loaded and reception continues
// - character done before buffer release sets overrun and error flags
// - release written in the load cycle counts as overrun
// - overrun error flag clears on writing 1; writing 0 does nothing
// - transmit done sets tx done flag; vector 00002C
// - buffer load sets rx done flag; vector 00002A
// - parity or framing error also sets rx done flag
// - all three errors share the error flag, vector 000028
// - request needs enable 1 and priority above cpu mask level
// - flags set even while their enable is 0
// - interrupt flags clear on writing 1; writing 0 does nothing
// - two-bit priority shared by the three sources, levels 0 to 3
// - config D0 selects serial pins when 1, port pins when 0; resets 0
// - D2:D1 mode: 11 async 8-bit, 10 async 7-bit, 01/00 synchronous; here 01/00 only hold the receiver idle
// - D4:D3 clock source: timer, osc/4, osc/8, osc/16; resets 00
// - D5 odd parity when 1, D6 parity enable; both reset 0
// - an overrun does not set the rx done flag
// - writing 0 to receive permit stops reception and clears error flags
module async_serial_rx_errors_and_irq #(
  parameter ADDR_W = 20
) (
  input  wire              aclk,
  input  wire              aresetn,
  input  wire [ADDR_W-1:0] awaddr,
  input  wire              awvalid,
  output reg               awready,
  input  wire [31:0]       wdata,
  input  wire [3:0]        wstrb,
  input  wire              wvalid,
  output reg               wready,
  output reg  [1:0]        bresp,
  output reg               bvalid,
  input  wire              bready,
  input  wire [ADDR_W-1:0] araddr,
  input  wire              arvalid,
  output reg               arready,
  output reg  [31:0]       rdata,
  output reg  [1:0]        rresp,
  output reg               rvalid,
  input  wire              rready,
  input  wire              serial_rx_pin,
  input  wire              timer_tick,
  input  wire              tx_shift_done,
  input  wire              cpu_mask_lo,
  input  wire              cpu_mask_hi,
  output reg               pin_function_select,
  output reg  [1:0]        xfer_mode,
  output reg  [1:0]        clk_src,
  output reg               tx_permit,
  output reg  [7:0]        rx_buffer,
  output reg               rx_load,
  output reg  [2:0]        irq_req,
  output reg  [23:0]       irq_vector
);

  localparam IDLE  = 2'b00;
  localparam START = 2'b01;
  localparam DATA  = 2'b10;
  localparam STOP  = 2'b11;

  reg        parity_enable;
  reg        parity_odd_select;
  reg        rx_permit;
  reg        buffer_full;
  reg        parity_err_flag;
  reg        frame_err_flag;
  reg        overrun_err_flag;
  reg        tx_done_irq_flag;
  reg        rx_done_irq_flag;
  reg        error_irq_flag;
  reg        tx_done_irq_en;
  reg        rx_done_irq_en;
  reg        error_irq_en;
  reg        serial_prio_lo;
  reg        serial_prio_hi;
  reg        rx_meta;
  reg        rx_sync;
  reg [3:0]  div_cnt;
  reg        tick;
  reg [1:0]  state;
  reg [3:0]  os_cnt;
  reg [3:0]  bit_cnt;
  reg [8:0]  shreg;
  reg [ADDR_W-1:0] wr_addr;
  reg [7:0]  wr_byte;
  reg        wr_en;
  reg [31:0] next_rdata;
  reg        rd_hit;

  wire       rx_line   = pin_function_select ? rx_sync : 1'b1;
  wire       async_on  = xfer_mode[1] & rx_permit;
  wire [3:0] char_bits = (xfer_mode[0] ? 4'd8 : 4'd7) + {3'b000, parity_enable};
  wire       stop_hit  = tick && state == STOP && os_cnt == `OS_LAST;
  // character bits collect at the top of shreg; move them down to bit 0
  wire [8:0] aligned   = shreg >> (4'h9 - char_bits);
  wire       par_bad   = parity_enable & ((^aligned) != parity_odd_select);
  // stop bit is read live at its sample, it never enters shreg
  wire       frm_bad   = ~rx_line;
  wire       wr_ctrl   = wr_en && wr_addr == `CTRL_ADDR;
  wire       wr_flag   = wr_en && wr_addr == `IRQ_FLAG_ADDR;
  wire       release_w = wr_ctrl && wr_byte[`CTRL_RELEASE];
  // a release landing with the load is too late to save the old byte
  wire       ovr_bad   = stop_hit & (buffer_full | release_w);
  wire       clear_err = wr_ctrl && !wr_byte[`CTRL_RX_PERMIT];
  wire [1:0] prio      = {serial_prio_hi, serial_prio_lo};
  wire       prio_ok   = prio > {cpu_mask_hi, cpu_mask_lo};

  // aw and w are taken together so the write never needs a holding slot
  always @(posedge aclk) begin
    if (!aresetn) begin
      awready <= 1'b0;
      wready  <= 1'b0;
      bvalid  <= 1'b0;
      bresp   <= `RESP_OKAY;
      wr_en   <= 1'b0;
      wr_addr <= {ADDR_W{1'b0}};
      wr_byte <= 8'h00;
    end else begin
      wr_en <= 1'b0;
      if (!awready && awvalid && wvalid && !bvalid && !wr_en) begin
        awready <= 1'b1;
        wready  <= 1'b1;
      end else begin
        awready <= 1'b0;
        wready  <= 1'b0;
      end
      if (awready) begin
        wr_en   <= wstrb[0];
        wr_addr <= awaddr;
        wr_byte <= wdata[7:0];
        bvalid  <= 1'b1;
        if (awaddr == `CFG_ADDR || awaddr == `CTRL_ADDR || awaddr == `IRQ_CTRL_ADDR ||
            awaddr == `IRQ_FLAG_ADDR)
          bresp <= `RESP_OKAY;
        else
          bresp <= `RESP_SLVERR;
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  always @* begin
    next_rdata = 32'h00000000;
    rd_hit     = 1'b1;
    if (araddr == `CFG_ADDR) begin
      next_rdata[6:0] = {parity_enable, parity_odd_select, clk_src, xfer_mode, pin_function_select};
    end else if (araddr == `CTRL_ADDR) begin
      next_rdata[`CTRL_FRAME]     = frame_err_flag;
      next_rdata[`CTRL_PARITY]    = parity_err_flag;
      next_rdata[`CTRL_OVERRUN]   = overrun_err_flag;
      next_rdata[`CTRL_RELEASE]   = async_on & ~buffer_full;
      next_rdata[`CTRL_RX_PERMIT] = rx_permit;
      next_rdata[`CTRL_TX_PERMIT] = tx_permit;
    end else if (araddr == `IRQ_CTRL_ADDR) begin
      next_rdata[`IRQ_PRIO_HI] = serial_prio_hi;
      next_rdata[`IRQ_PRIO_LO] = serial_prio_lo;
      next_rdata[2:0]          = {error_irq_en, rx_done_irq_en, tx_done_irq_en};
    end else if (araddr == `IRQ_FLAG_ADDR) begin
      next_rdata[2:0] = {error_irq_flag, rx_done_irq_flag, tx_done_irq_flag};
    end else begin
      rd_hit = 1'b0;
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b0;
      rvalid  <= 1'b0;
      rdata   <= 32'h00000000;
      rresp   <= `RESP_OKAY;
    end else begin
      arready <= !arready && arvalid && !rvalid;
      if (arready) begin
        rvalid <= 1'b1;
        rdata  <= next_rdata;
        rresp  <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
      end else if (rvalid && rready) begin
        rvalid <= 1'b0;
      end
    end
  end

  // configuration and enables
  always @(posedge aclk) begin
    if (!aresetn) begin
      {parity_enable, parity_odd_select, clk_src, xfer_mode, pin_function_select} <= `CFG_RESET;
      rx_permit      <= 1'b0;
      tx_permit      <= 1'b0;
      tx_done_irq_en <= 1'b0;
      rx_done_irq_en <= 1'b0;
      error_irq_en   <= 1'b0;
      serial_prio_lo <= 1'b0;
      serial_prio_hi <= 1'b0;
    end else if (wr_en) begin
      // no storage behind bit 7, so a write there falls away
      if (wr_addr == `CFG_ADDR) begin
        pin_function_select <= wr_byte[`CFG_PIN_SEL];
        xfer_mode           <= wr_byte[`CFG_MODE_HI:`CFG_MODE_LO];
        clk_src             <= wr_byte[`CFG_SRC_HI:`CFG_SRC_LO];
        parity_odd_select   <= wr_byte[`CFG_ODD];
        parity_enable       <= wr_byte[`CFG_PAR_EN];
      end else if (wr_addr == `CTRL_ADDR) begin
        rx_permit <= wr_byte[`CTRL_RX_PERMIT];
        tx_permit <= wr_byte[`CTRL_TX_PERMIT];
      end else if (wr_addr == `IRQ_CTRL_ADDR) begin
        tx_done_irq_en <= wr_byte[`IRQ_TX];
        rx_done_irq_en <= wr_byte[`IRQ_RX];
        error_irq_en   <= wr_byte[`IRQ_ERR];
        serial_prio_lo <= wr_byte[`IRQ_PRIO_LO];
        serial_prio_hi <= wr_byte[`IRQ_PRIO_HI];
      end
    end
  end

  // pin crosses into aclk through two flops
  always @(posedge aclk) begin
    if (!aresetn) begin
      rx_meta <= 1'b1;
      rx_sync <= 1'b1;
    end else begin
      rx_meta <= serial_rx_pin;
      rx_sync <= rx_meta;
    end
  end

  // sample tick: aclk stands in for the main oscillator
  // timer_tick is taken as a one-cycle pulse already on aclk
  always @(posedge aclk) begin
    if (!aresetn) begin
      div_cnt <= 4'h0;
      tick    <= 1'b0;
    end else begin
      div_cnt <= div_cnt + 4'h1;
      case (clk_src)
        2'b11:   tick <= timer_tick;
        2'b10:   tick <= div_cnt[1:0] == 2'b11;
        2'b01:   tick <= div_cnt[2:0] == 3'b111;
        default: tick <= div_cnt == 4'hF;
      endcase
    end
  end

  // receiver, 16 ticks per bit
  always @(posedge aclk) begin
    if (!aresetn) begin
      state   <= IDLE;
      os_cnt  <= 4'h0;
      bit_cnt <= 4'h0;
      shreg   <= 9'h000;
    end else if (!async_on) begin
      state <= IDLE;
    end else if (tick) begin
      os_cnt <= os_cnt + 4'h1;
      case (state)
        IDLE: begin
          os_cnt <= 4'h0;
          if (!rx_line)
            state <= START;
        end
        START: begin
          // a start that is high again at mid-bit is a glitch, not a frame
          if (os_cnt == `OS_MID) begin
            os_cnt  <= 4'h0;
            bit_cnt <= 4'h0;
            state   <= rx_line ? IDLE : DATA;
          end
        end
        DATA: begin
          if (os_cnt == `OS_LAST) begin
            shreg   <= {rx_line, shreg[8:1]};
            bit_cnt <= bit_cnt + 4'h1;
            if (bit_cnt == char_bits - 4'h1)
              state <= STOP;
          end
        end
        default: begin
          if (os_cnt == `OS_LAST)
            state <= IDLE;
        end
      endcase
    end
  end

  // buffer load and error flags; a set wins over a clear in the same cycle
  always @(posedge aclk) begin
    if (!aresetn) begin
      rx_buffer        <= 8'h00;
      rx_load          <= 1'b0;
      buffer_full      <= 1'b0;
      parity_err_flag  <= 1'b0;
      frame_err_flag   <= 1'b0;
      overrun_err_flag <= 1'b0;
    end else begin
      rx_load <= stop_hit & async_on;
      if (stop_hit & async_on) begin
        // 7-bit mode leaves the parity bit in bit 7, masked off here
        rx_buffer   <= aligned[7:0] & (xfer_mode[0] ? 8'hFF : 8'h7F);
        buffer_full <= 1'b1;
      end else if (release_w) begin
        buffer_full <= 1'b0;
      end
      if (stop_hit & async_on & par_bad)
        parity_err_flag <= 1'b1;
      else if (clear_err || (wr_ctrl && wr_byte[`CTRL_PARITY]))
        parity_err_flag <= 1'b0;
      if (stop_hit & async_on & frm_bad)
        frame_err_flag <= 1'b1;
      else if (clear_err || (wr_ctrl && wr_byte[`CTRL_FRAME]))
        frame_err_flag <= 1'b0;
      if (async_on & ovr_bad)
        overrun_err_flag <= 1'b1;
      else if (clear_err || (wr_ctrl && wr_byte[`CTRL_OVERRUN]))
        overrun_err_flag <= 1'b0;
    end
  end

  // interrupt factor flags, set even while disabled
  always @(posedge aclk) begin
    if (!aresetn) begin
      tx_done_irq_flag <= 1'b0;
      rx_done_irq_flag <= 1'b0;
      error_irq_flag   <= 1'b0;
    end else begin
      if (tx_shift_done)
        tx_done_irq_flag <= 1'b1;
      else if (wr_flag && wr_byte[`IRQ_TX])
        tx_done_irq_flag <= 1'b0;
      if (stop_hit & async_on & ~ovr_bad)
        rx_done_irq_flag <= 1'b1;
      else if (wr_flag && wr_byte[`IRQ_RX])
        rx_done_irq_flag <= 1'b0;
      if (stop_hit & async_on & (par_bad | frm_bad | ovr_bad))
        error_irq_flag <= 1'b1;
      else if (wr_flag && wr_byte[`IRQ_ERR])
        error_irq_flag <= 1'b0;
    end
  end

  // requests to the cpu; the vector ranks error over receive, receive over transmit
  always @(posedge aclk) begin
    if (!aresetn) begin
      irq_req    <= 3'b000;
      irq_vector <= 24'h000000;
    end else begin
      irq_req[`IRQ_TX]  <= tx_done_irq_flag & tx_done_irq_en & prio_ok;
      irq_req[`IRQ_RX]  <= rx_done_irq_flag & rx_done_irq_en & prio_ok;
      irq_req[`IRQ_ERR] <= error_irq_flag & error_irq_en & prio_ok;
      // vector ignores the mask level; only irq_req waits on it
      if (error_irq_flag & error_irq_en)
        irq_vector <= `VEC_ERROR;
      else if (rx_done_irq_flag & rx_done_irq_en)
        irq_vector <= `VEC_RX_DONE;
      else if (tx_done_irq_flag & tx_done_irq_en)
        irq_vector <= `VEC_TX_DONE;
      else
        irq_vector <= 24'h000000;
    end
  end

endmodule

/* tb/async_serial_rx_errors_and_irq_props.sv */
`timescale 1ns/1ns
module serial_irq_props (
  input wire        aclk,
  input wire        aresetn,
  input wire        awready,
  input wire        wready,
  input wire        bvalid,
  input wire        arready,
  input wire        rvalid,
  input wire        cpu_mask_lo,
  input wire        cpu_mask_hi,
  input wire        pin_function_select,
  input wire [1:0]  xfer_mode,
  input wire [1:0]  clk_src,
  input wire        rx_load,
  input wire [2:0]  irq_req,
  input wire [23:0] irq_vector
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_aw_w; awready |-> wready; endproperty
  a_aw_w: assert property (p_aw_w) else $error("address taken without data");
  property p_b_next; awready |=> bvalid; endproperty
  a_b_next: assert property (p_b_next) else $error("write response late");
  property p_r_next; arready |=> rvalid; endproperty
  a_r_next: assert property (p_r_next) else $error("read data late");
  property p_load; rx_load |=> !rx_load; endproperty
  a_load: assert property (p_load) else $error("load strobe longer than one cycle");
  property p_mask; irq_req != 3'h0 |-> $past({cpu_mask_hi, cpu_mask_lo}) != 2'h3; endproperty
  a_mask: assert property (p_mask) else $error("request above top mask level");
  property p_vec_err; irq_req[2] |-> irq_vector == 24'h000028; endproperty
  a_vec_err: assert property (p_vec_err) else $error("error vector wrong");
  property p_vec_rx; irq_req[1] && !irq_req[2] |-> irq_vector == 24'h00002A; endproperty
  a_vec_rx: assert property (p_vec_rx) else $error("receive vector wrong");
  property p_vec_tx; irq_req == 3'h1 |-> irq_vector == 24'h00002C; endproperty
  a_vec_tx: assert property (p_vec_tx) else $error("transmit vector wrong");
  property p_rst; $rose(aresetn) |-> !pin_function_select && xfer_mode == 2'h0 && clk_src == 2'h0; endproperty
  a_rst: assert property (p_rst) else $error("config not cleared by reset");
  c_load: cover property (rx_load);
  c_err: cover property (irq_req[2]);
  c_tx: cover property (irq_req == 3'h1);
endmodule
bind async_serial_rx_errors_and_irq serial_irq_props u_props (.aclk(aclk), .aresetn(aresetn),
  .awready(awready), .wready(wready), .bvalid(bvalid), .arready(arready), .rvalid(rvalid),
  .cpu_mask_lo(cpu_mask_lo), .cpu_mask_hi(cpu_mask_hi), .pin_function_select(pin_function_select),
  .xfer_mode(xfer_mode), .clk_src(clk_src), .rx_load(rx_load), .irq_req(irq_req), .irq_vector(irq_vector));

/* tb/serial_peer.sv */
`timescale 1ns/1ns
module serial_peer #(
  parameter BIT = 64
) (
  input  wire aclk,
  output reg  line
);
  initial line = 1'b1;
  // flip breaks parity on purpose; idle line stays high between frames
  task automatic send(input [7:0] d, input pen, input odd, input flip, input stp, input seven,
                      input integer scale);
    reg [10:0] f;
    reg        p;
    integer    i;
    begin
      p = ^(seven ? {1'b0, d[6:0]} : d) ^ odd ^ flip;
      if (seven)
        f = pen ? {1'b1, stp, p, d[6:0], 1'b0} : {2'b11, stp, d[6:0], 1'b0};
      else
        f = pen ? {stp, p, d, 1'b0} : {1'b1, stp, d, 1'b0};
      for (i = 0; i < 11; i = i + 1) begin
        line <= f[i];
        repeat (BIT * scale) @(posedge aclk);
      end
      line <= 1'b1;
    end
  endtask
endmodule

/* tb/async_serial_rx_errors_and_irq_tb.sv */
`timescale 1ns/1ns
`include "serial_rx_err_regs.vh"
`define CHK(a, e) chk({a}, {e})
module async_serial_rx_errors_and_irq_tb;
  reg         aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, timer_tick, tx_shift_done;
  reg         cpu_mask_lo, cpu_mask_hi;
  reg         sev;
  reg  [1:0]  tq = 2'h0;
  reg  [19:0] awaddr, araddr;
  reg  [31:0] wdata;
  reg  [3:0]  wstrb;
  wire        awready, wready, bvalid, arready, rvalid, rx_load, serial_rx_pin, pin_function_select, tx_permit;
  wire [1:0]  bresp, rresp, xfer_mode, clk_src;
  wire [31:0] rdata;
  wire [7:0]  rx_buffer;
  wire [2:0]  irq_req;
  wire [23:0] irq_vector;
  integer     miscompares, compares, seed, n, k, mul;
  reg  [33:0] rq[$];
  reg  [1:0]  bq[$];
  reg  [7:0]  xq[$];
  reg  [7:0]  d;
  async_serial_rx_errors_and_irq u_dut (.*);
  serial_peer #(.BIT(64)) u_peer (.aclk(aclk), .line(serial_rx_pin));
  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end
  task chk(input [33:0] a, input [33:0] e);
    begin
      compares = compares + 1;
      if (a !== e) begin
        miscompares = miscompares + 1;
        $display("[FAIL] %0t mismatch got %h exp %h", $time, a, e);
      end
    end
  endtask
  task end_sim;
    begin
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0)
        $display("*** PASS ***");
      else
        $display("*** FAIL ***");
      $finish;
    end
  endtask
  task tmo;
    begin
      if (n >= 99) begin
        miscompares = miscompares + 1;
        $display("[FAIL] %0t handshake timeout", $time);
        end_sim;
      end
    end
  endtask
  task wr(input [19:0] a, input [7:0] v, input [1:0] r);
    begin
      bq.push_back(r);
      awaddr <= a;
      wdata <= {24'h000000, v};
      wstrb <= 4'hF;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      n = 0;
      do begin @(posedge aclk); n = n + 1; end while (!awready && n < 99);
      awvalid <= 1'b0;
      wvalid <= 1'b0;
      do begin @(posedge aclk); n = n + 1; end while (!bvalid && n < 99);
      tmo;
    end
  endtask
  task rd(input [19:0] a, input [33:0] e);
    begin
      rq.push_back(e);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      n = 0;
      do begin @(posedge aclk); n = n + 1; end while (!arready && n < 99);
      arvalid <= 1'b0;
      do begin @(posedge aclk); n = n + 1; end while (!rvalid && n < 99);
      tmo;
    end
  endtask
  // one character; rel releases the buffer and clears errors first
  task frame(input rel, input pen, input odd, input flip, input stp, input [7:0] ectl, input [7:0] eflg);
    begin
      if (rel)
        wr(`CTRL_ADDR, 8'h7C, 2'h0);
      wr(`IRQ_FLAG_ADDR, 8'h07, 2'h0);
      d = $random(seed);
      xq.push_back(sev ? {1'b0, d[6:0]} : d);
      u_peer.send(d, pen, odd, flip, stp, sev, mul);
      repeat (4) @(posedge aclk);
      rd(`CTRL_ADDR, {26'h0, ectl});
      rd(`IRQ_FLAG_ADDR, {26'h0, eflg});
    end
  endtask
  always @(posedge aclk) begin
    if (rvalid && rready)
      `CHK({rresp, rdata}, rq.pop_front());
    if (bvalid && bready)
      `CHK(bresp, bq.pop_front());
    if (rx_load)
      `CHK(rx_buffer, xq.pop_front());
  end
  // stand-in timer: one pulse every fourth clock, same rate as the osc/4 tick
  always @(posedge aclk) begin
    tq <= tq + 2'h1;
    timer_tick <= tq == 2'h3;
  end
  initial begin
    #5000000;
    miscompares = miscompares + 1;
    $display("[FAIL] %0t run timeout", $time);
    end_sim;
  end
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, tx_shift_done} = 7'h00;
    {cpu_mask_lo, cpu_mask_hi, awaddr, araddr, wdata, wstrb} = 0;
    miscompares = 0;
    compares = 0;
    seed = 33;
    sev = 1'b0;
    mul = 1;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(`CFG_ADDR, 34'h0);
    rd(`CTRL_ADDR, 34'h0);
    rd(`IRQ_FLAG_ADDR, 34'h0);
    wr(20'h00010, 8'h55, 2'h2);
    rd(20'h00010, {2'h2, 32'h0});
    wr(`CFG_ADDR, 8'hFF, 2'h0);
    rd(`CFG_ADDR, 34'h7F);
    `CHK({pin_function_select, xfer_mode, clk_src}, 5'h1F);
    wr(`CTRL_ADDR, 8'h01, 2'h0);
    rd(`CTRL_ADDR, 34'h01);
    `CHK(tx_permit, 1'b1);
    $display("registers done");
    for (k = 0; k < 2; k = k + 1) begin
      wr(`IRQ_CTRL_ADDR, k ? 8'h37 : 8'h30, 2'h0);
      wr(`CFG_ADDR, k ? 8'h77 : 8'h57, 2'h0);
      frame(1, 1, k, 0, 1, 8'h04, 8'h02);
      frame(1, 1, k, 1, 1, 8'h24, 8'h06);
    end
    wr(`CTRL_ADDR, 8'h04, 2'h0);
    rd(`CTRL_ADDR, 34'h24);
    wr(`CTRL_ADDR, 8'h24, 2'h0);
    rd(`CTRL_ADDR, 34'h04);
    frame(1, 1, 1, 0, 0, 8'h44, 8'h06);
    wr(`CTRL_ADDR, 8'h04, 2'h0);
    rd(`CTRL_ADDR, 34'h44);
    wr(`CTRL_ADDR, 8'h44, 2'h0);
    frame(0, 1, 1, 0, 1, 8'h14, 8'h04);
    wr(`CTRL_ADDR, 8'h04, 2'h0);
    rd(`CTRL_ADDR, 34'h14);
    wr(`CTRL_ADDR, 8'h00, 2'h0);
    rd(`CTRL_ADDR, 34'h00);
    wr(`CFG_ADDR, 8'h37, 2'h0);
    frame(1, 0, 0, 1, 1, 8'h04, 8'h02);
    sev = 1'b1;
    wr(`CFG_ADDR, 8'h5D, 2'h0);
    frame(1, 1, 0, 1, 1, 8'h24, 8'h06);
    mul = 2;
    wr(`CFG_ADDR, 8'h4D, 2'h0);
    frame(1, 1, 0, 0, 1, 8'h04, 8'h02);
    mul = 4;
    wr(`CFG_ADDR, 8'h45, 2'h0);
    frame(1, 1, 0, 0, 1, 8'h04, 8'h02);
    $display("receive errors done");
    wr(`IRQ_FLAG_ADDR, 8'h07, 2'h0);
    tx_shift_done <= 1'b1;
    @(posedge aclk);
    tx_shift_done <= 1'b0;
    repeat (3) @(posedge aclk);
    `CHK({irq_req, irq_vector}, {3'h1, 24'h00002C});
    {cpu_mask_hi, cpu_mask_lo} <= 2'h3;
    repeat (2) @(posedge aclk);
    `CHK(irq_req, 3'h0);
    wr(`IRQ_FLAG_ADDR, 8'h00, 2'h0);
    rd(`IRQ_FLAG_ADDR, 34'h01);
    wr(`IRQ_FLAG_ADDR, 8'h01, 2'h0);
    rd(`IRQ_FLAG_ADDR, 34'h00);
    `CHK(xq.size(), 0);
    $display("interrupts done");
    end_sim;
  end
endmodule
